// [logic/apr_params.svh]
// Constants of the audio pin routing block: register offsets, field
// positions, reset values and selection codes.
// Assumes an 8-bit register port with byte-wide offsets.
//
// Summary of operation
// RL1: Primary data input enable at bit 7, resets to one; zero blocks it.
// RL2: Bits 6..4 pick secondary frame source; zero disables, 4,6,7 reserved.
// RL3: Bits 3..1 pick secondary bit clock source; same codes as frame.
// RL4: Bits 7..5 route secondary input one; 4 data-out pin, 5 primary input.
// RL5: Bits 4..2 route secondary input two with the same codes.
// RL6: Bit 7 makes record channel 1 digital microphone, else analog.
// RL7: Bit 6 makes record channel 2 digital microphone, else analog.
// RL8: Bit 5 swaps line one edges; default channel 1 falling, 2 rising.
// RL9: Bit 4 swaps line two edges; default channel 3 falling, 4 rising.
// RL10: Bits 3..2 pick the pin carrying microphone line one.
// RL11: Bits 1..0 pick the pin carrying microphone line two.
// RL12: Override bit 7 turns an input_pin_1a line choice into the data input pin.
// RL13: Bit 6 makes the data-out pin both output and data input.
// RL14: Bits 5..4 pick a power-down pin; either pin or control powers down.
// RL15: Bit 0 assigns the auxiliary function to general_io_pin_one.
// RL16: Reserved bits read zero; software writes only zero there.
// RL17: Data-out function field resets to 5, the primary data output.
// RL18: Reserved routing codes leave the routed signal disconnected.
`ifndef APR_PARAMS_SVH
`define APR_PARAMS_SVH

// ==========
// Register offsets
`define APR_OFS_DOUT_CFG 8'h10
`define APR_OFS_CLK_ROUTE 8'h11
`define APR_OFS_DATA_ROUTE 8'h12
`define APR_OFS_MIC_CFG 8'h13
`define APR_OFS_OVERRIDES 8'h14

// ==========
// Reset values and writable-bit masks
`define APR_RST_DOUT_CFG 8'h50
`define APR_RST_CLK_ROUTE 8'h80
`define APR_RST_DATA_ROUTE 8'h00
`define APR_RST_MIC_CFG 8'h00
`define APR_RST_OVERRIDES 8'h00
`define APR_MASK_DOUT_CFG 8'hf0
`define APR_MASK_CLK_ROUTE 8'hfe
`define APR_MASK_DATA_ROUTE 8'hfc
`define APR_MASK_MIC_CFG 8'hff
`define APR_MASK_OVERRIDES 8'hf1

// ==========
// Field positions
`define APR_DOUT_FUNC_MSB 7
`define APR_DOUT_FUNC_LSB 4
`define APR_PRIM_EN_BIT 7
`define APR_FRAME_MSB 6
`define APR_FRAME_LSB 4
`define APR_BCLK_MSB 3
`define APR_BCLK_LSB 1
`define APR_IN1_MSB 7
`define APR_IN1_LSB 5
`define APR_IN2_MSB 4
`define APR_IN2_LSB 2
`define APR_CH1_DIG_BIT 7
`define APR_CH2_DIG_BIT 6
`define APR_EDGE1_BIT 5
`define APR_EDGE2_BIT 4
`define APR_LINE1_MSB 3
`define APR_LINE1_LSB 2
`define APR_LINE2_MSB 1
`define APR_LINE2_LSB 0
`define APR_OVRD_BIT 7
`define APR_DOUT_DIN_BIT 6
`define APR_PD_MSB 5
`define APR_PD_LSB 4
`define APR_AUX_BIT 0

// ==========
// Selection codes
`define APR_SRC_OFF 3'h0
`define APR_SRC_PIN1 3'h1
`define APR_SRC_PIN2A 3'h2
`define APR_SRC_PIN1A 3'h3
`define APR_SRC_DOUT 3'h4
`define APR_SRC_PRIM 3'h5
`define APR_DOUT_FN_INPUT 4'h1
`define APR_DOUT_FN_PRIMARY 4'h5

`endif

// [logic/apr_pkg.sv]
// Types shared by the audio pin routing modules.
// Assumes apr_params.svh supplies all numeric constants.
package apr_pkg;

    // ==========
    // Register and output state of the top module
    typedef struct packed {
        logic [7:0] dout_cfg;
        logic [7:0] clk_route;
        logic [7:0] data_route;
        logic [7:0] mic_cfg;
        logic [7:0] overrides;
        logic [7:0] rdata;
        logic mic_clk_prev;
        logic sp_frame;
        logic sp_bclk;
        logic sp_enable;
        logic sp_in1;
        logic sp_in2;
        logic prim_data;
        logic powered_down;
        logic dout_drive;
        logic dout_oe_n;
        logic ch1_digital;
        logic ch2_digital;
        logic aux_on_pin1;
        logic rise;
        logic fall;
        logic [1:0] line_data;
        logic [1:0] line_enable;
    } apr_top_state_t;

    // ==========
    // State of one microphone line capture
    typedef struct packed {
        logic first_bit;
        logic second_bit;
        logic first_strobe;
        logic second_strobe;
    } apr_mic_state_t;

endpackage : apr_pkg

// [logic/apr_mic_if.sv]
// Carrier between the top module and one microphone line capture.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none

interface apr_mic_if;
    logic clk_rise;
    logic clk_fall;
    logic data;
    logic edge_swap;
    logic enable;
    logic first_bit;
    logic second_bit;
    logic first_strobe;
    logic second_strobe;

    modport capture (
        input clk_rise, clk_fall, data, edge_swap, enable,
        output first_bit, second_bit, first_strobe, second_strobe
    );
    modport owner (
        output clk_rise, clk_fall, data, edge_swap, enable,
        input first_bit, second_bit, first_strobe, second_strobe
    );
endinterface : apr_mic_if

`default_nettype wire

// [logic/apr_sync.sv]
// Two-stage synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is an independent level; no word coherence is given.
`timescale 1ns/1ps
`default_nettype none

module apr_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } apr_sync_state_t;

    apr_sync_state_t state_ff;
    apr_sync_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.meta = async_in;
        nxt_state.stable = state_ff.meta;
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sync_out = state_ff.stable;
endmodule : apr_sync

`default_nettype wire

// [logic/apr_mic_capture.sv]
// Captures the two channels interleaved on one microphone data line.
// Assumes clock edge pulses come from an already synchronised clock.
`timescale 1ns/1ps
`default_nettype none

module apr_mic_capture (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // Line
    apr_mic_if.capture line
);
    apr_pkg::apr_mic_state_t state_ff;
    apr_pkg::apr_mic_state_t nxt_state;

    // The first channel of the pair is taken on the falling edge unless the
    // edge swap is set.
    always_comb begin
        nxt_state = state_ff;
        nxt_state.first_strobe = 1'b0;
        nxt_state.second_strobe = 1'b0;
        if (line.enable) begin
            if ((line.clk_fall && !line.edge_swap) ||
                (line.clk_rise && line.edge_swap)) begin
                nxt_state.first_bit = line.data; // see RL8 see RL9
                nxt_state.first_strobe = 1'b1;
            end
            if ((line.clk_rise && !line.edge_swap) ||
                (line.clk_fall && line.edge_swap)) begin
                nxt_state.second_bit = line.data; // see RL8 see RL9
                nxt_state.second_strobe = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign line.first_bit = state_ff.first_bit;
    assign line.second_bit = state_ff.second_bit;
    assign line.first_strobe = state_ff.first_strobe;
    assign line.second_strobe = state_ff.second_strobe;
endmodule : apr_mic_capture

`default_nettype wire

// [logic/apr_pin_routing.sv]
// Top of the audio pin routing block: configuration registers, routing of
// multipurpose pins to the secondary serial port and microphone lines,
// converter power-down and data-out pin control.
// Assumes a synchronous 8-bit register port on the system clock and
// asynchronous pins that are synchronised here.
`include "apr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module apr_pin_routing (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    // Multipurpose input pins
    input wire logic general_io_pin_one_in,
    input wire logic input_pin_2a_in,
    input wire logic input_pin_1a_in,
    input wire logic serial_data_in,
    // Data-out pin, three signals
    input wire logic data_out_pin_in,
    output logic data_out_pin_out,
    output logic data_out_pin_oe_n_out,
    // Primary serial port pins and data
    input wire logic primary_frame_in,
    input wire logic primary_bitclock_in,
    input wire logic primary_data_out_in,
    output logic primary_data_input_out,
    // Secondary serial port
    output logic second_port_enable_out,
    output logic second_port_frame_out,
    output logic second_port_bitclock_out,
    output logic second_port_input_one_out,
    output logic second_port_input_two_out,
    // Microphones
    input wire logic mic_bit_clock_in,
    output logic channel_one_digital_out,
    output logic channel_two_digital_out,
    output logic [3:0] mic_channel_bit_out,
    output logic [3:0] mic_channel_strobe_out,
    // Converter and auxiliary function
    input wire logic converter_powerdown_control_in,
    output logic converter_powered_down_out,
    output logic aux_function_on_pin_one_out
);
    localparam int NUM_PINS = 8;
    localparam int NUM_LINES = 2;

    // ==========
    // Pin synchronisation
    logic [NUM_PINS-1:0] pins_raw;
    logic [NUM_PINS-1:0] pins_sync;

    logic pin_one_s;
    logic pin_2a_s;
    logic pin_1a_s;
    logic din_s;
    logic dout_pin_s;
    logic prim_frame_s;
    logic prim_bclk_s;
    logic mic_clk_s;

    assign pins_raw = {mic_bit_clock_in, primary_bitclock_in,
                       primary_frame_in, data_out_pin_in, serial_data_in,
                       input_pin_1a_in, input_pin_2a_in,
                       general_io_pin_one_in};

    apr_sync #(
        .WIDTH(NUM_PINS)
    ) u_sync (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    assign pin_one_s = pins_sync[0];
    assign pin_2a_s = pins_sync[1];
    assign pin_1a_s = pins_sync[2];
    assign din_s = pins_sync[3];
    assign dout_pin_s = pins_sync[4];
    assign prim_frame_s = pins_sync[5];
    assign prim_bclk_s = pins_sync[6];
    assign mic_clk_s = pins_sync[7];

    // ==========
    // Routing helpers

    // Any code outside the listed ones returns zero, so a reserved
    // selection leaves the destination disconnected.
    function automatic logic route_pin(
        input logic [2:0] code,
        input logic pin1,
        input logic pin2a,
        input logic pin1a,
        input logic dout_in,
        input logic prim
    );
        logic val;
        val = 1'b0;
        case (code)
            `APR_SRC_PIN1: val = pin1;
            `APR_SRC_PIN2A: val = pin2a;
            `APR_SRC_PIN1A: val = pin1a;
            `APR_SRC_DOUT: val = dout_in;
            `APR_SRC_PRIM: val = prim;
            default: val = 1'b0; // see RL18
        endcase
        return val;
    endfunction : route_pin

    // Clock sources have no data-out choice; code 4 is reserved there.
    function automatic logic clock_code_ok(input logic [2:0] code);
        return (code == `APR_SRC_PIN1) || (code == `APR_SRC_PIN2A) ||
               (code == `APR_SRC_PIN1A) || (code == `APR_SRC_PRIM);
    endfunction : clock_code_ok

    function automatic logic [7:0] merge_write(
        input logic [7:0] data,
        input logic [7:0] mask
    );
        return data & mask; // see RL16
    endfunction : merge_write

    // ==========
    // State
    apr_pkg::apr_top_state_t state_ff;
    apr_pkg::apr_top_state_t nxt_state;

    logic [3:0] dout_func;
    logic [2:0] frame_code;
    logic [2:0] bclk_code;
    logic [2:0] in1_code;
    logic [2:0] in2_code;
    logic [1:0] pd_code;

    logic mic_override;
    logic dout_with_din;
    logic dout_as_input;
    logic dout_input_val;
    logic pd_pin_val;

    logic [1:0] line_code [NUM_LINES];
    logic [NUM_LINES-1:0] line_edge;

    assign dout_func = state_ff.dout_cfg[`APR_DOUT_FUNC_MSB:`APR_DOUT_FUNC_LSB];
    assign frame_code = state_ff.clk_route[`APR_FRAME_MSB:`APR_FRAME_LSB];
    assign bclk_code = state_ff.clk_route[`APR_BCLK_MSB:`APR_BCLK_LSB];
    assign in1_code = state_ff.data_route[`APR_IN1_MSB:`APR_IN1_LSB];
    assign in2_code = state_ff.data_route[`APR_IN2_MSB:`APR_IN2_LSB];

    assign pd_code = state_ff.overrides[`APR_PD_MSB:`APR_PD_LSB];
    assign mic_override = state_ff.overrides[`APR_OVRD_BIT];
    assign dout_with_din = state_ff.overrides[`APR_DOUT_DIN_BIT];

    assign line_code[0] = state_ff.mic_cfg[`APR_LINE1_MSB:`APR_LINE1_LSB];
    assign line_code[1] = state_ff.mic_cfg[`APR_LINE2_MSB:`APR_LINE2_LSB];
    assign line_edge[0] = state_ff.mic_cfg[`APR_EDGE1_BIT];
    assign line_edge[1] = state_ff.mic_cfg[`APR_EDGE2_BIT];

    // The data-out pin is read back either when its function is plain
    // input or when it is shared between output and input.
    assign dout_as_input = dout_with_din || // see RL13
                           (dout_func == `APR_DOUT_FN_INPUT);
    assign dout_input_val = dout_as_input & dout_pin_s;
    assign pd_pin_val = route_pin(
        {1'b0, pd_code},
        pin_one_s,
        pin_2a_s,
        pin_1a_s,
        1'b0,
        1'b0);

    // ==========
    // Next state
    always_comb begin
        logic [2:0] lc;
        lc = 3'h0;
        nxt_state = state_ff;

        // Register writes; reserved bits are forced to zero on write.
        if (reg_write_in) begin
            case (reg_addr_in)
                `APR_OFS_DOUT_CFG: nxt_state.dout_cfg =
                    merge_write(reg_wdata_in, `APR_MASK_DOUT_CFG);
                `APR_OFS_CLK_ROUTE: nxt_state.clk_route =
                    merge_write(reg_wdata_in, `APR_MASK_CLK_ROUTE);
                `APR_OFS_DATA_ROUTE: nxt_state.data_route =
                    merge_write(reg_wdata_in, `APR_MASK_DATA_ROUTE);
                `APR_OFS_MIC_CFG: nxt_state.mic_cfg =
                    merge_write(reg_wdata_in, `APR_MASK_MIC_CFG);
                `APR_OFS_OVERRIDES: nxt_state.overrides =
                    merge_write(reg_wdata_in, `APR_MASK_OVERRIDES);
                default: ;
            endcase
        end

        // Reads return stored values; unmapped offsets read zero.
        if (reg_read_in) begin
            case (reg_addr_in)
                `APR_OFS_DOUT_CFG: nxt_state.rdata = state_ff.dout_cfg;
                `APR_OFS_CLK_ROUTE: nxt_state.rdata = state_ff.clk_route;
                `APR_OFS_DATA_ROUTE: nxt_state.rdata = state_ff.data_route;
                `APR_OFS_MIC_CFG: nxt_state.rdata = state_ff.mic_cfg;
                `APR_OFS_OVERRIDES: nxt_state.rdata = state_ff.overrides;
                default: nxt_state.rdata = 8'h00;
            endcase
        end

        // Secondary port clocks; the port runs only with both sources
        // set to valid codes.
        nxt_state.sp_enable = clock_code_ok(frame_code) && // see RL2
                              clock_code_ok(bclk_code); // see RL3
        nxt_state.sp_frame = clock_code_ok(frame_code) && route_pin(
            frame_code,
            pin_one_s,
            pin_2a_s,
            pin_1a_s,
            1'b0,
            prim_frame_s); // see RL2
        nxt_state.sp_bclk = clock_code_ok(bclk_code) && route_pin(
            bclk_code,
            pin_one_s,
            pin_2a_s,
            pin_1a_s,
            1'b0,
            prim_bclk_s); // see RL3

        // Secondary port data inputs.
        nxt_state.sp_in1 = route_pin(
            in1_code,
            pin_one_s,
            pin_2a_s,
            pin_1a_s,
            dout_input_val,
            din_s); // see RL4
        nxt_state.sp_in2 = route_pin(
            in2_code,
            pin_one_s,
            pin_2a_s,
            pin_1a_s,
            dout_input_val,
            din_s); // see RL5

        // Primary port data input gate.
        nxt_state.prim_data = din_s &
            state_ff.clk_route[`APR_PRIM_EN_BIT]; // see RL1

        // Converter is down when either the pin or the control asks.
        nxt_state.powered_down = pd_pin_val || // see RL14
                                 converter_powerdown_control_in;

        // Data-out pin drive. Functions other than primary output are
        // served elsewhere, so the pin is released for them unless bit 6
        // of the overrides shares it between output and input.
        if ((dout_func == `APR_DOUT_FN_PRIMARY) || dout_with_din) begin
            nxt_state.dout_drive = primary_data_out_in; // see RL13 see RL17
            nxt_state.dout_oe_n = 1'b0;
        end else begin
            nxt_state.dout_drive = 1'b0;
            nxt_state.dout_oe_n = 1'b1;
        end

        nxt_state.ch1_digital = state_ff.mic_cfg[`APR_CH1_DIG_BIT]; // see RL6
        nxt_state.ch2_digital = state_ff.mic_cfg[`APR_CH2_DIG_BIT]; // see RL7
        nxt_state.aux_on_pin1 = state_ff.overrides[`APR_AUX_BIT]; // see RL15

        // Microphone clock edges from the synchronised clock.
        nxt_state.mic_clk_prev = mic_clk_s;
        nxt_state.rise = mic_clk_s & ~state_ff.mic_clk_prev;
        nxt_state.fall = ~mic_clk_s & state_ff.mic_clk_prev;

        // Microphone line data, aligned with the edge pulses above.
        for (int i = 0; i < NUM_LINES; i++) begin
            lc = {1'b0, line_code[i]};
            nxt_state.line_enable[i] = (lc != `APR_SRC_OFF); // see RL10 see RL11
            if ((lc == `APR_SRC_PIN1A) && mic_override) begin
                nxt_state.line_data[i] = din_s; // see RL12
            end else begin
                nxt_state.line_data[i] = route_pin(lc, pin_one_s, pin_2a_s,
                    pin_1a_s, 1'b0, 1'b0); // see RL10 see RL11
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_ff <= '0;
            state_ff.dout_cfg <= `APR_RST_DOUT_CFG; // see RL17
            state_ff.clk_route <= `APR_RST_CLK_ROUTE; // see RL1
            state_ff.data_route <= `APR_RST_DATA_ROUTE;
            state_ff.mic_cfg <= `APR_RST_MIC_CFG;
            state_ff.overrides <= `APR_RST_OVERRIDES;
            state_ff.dout_oe_n <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========
    // Microphone line captures
    generate
        for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
            apr_mic_if mic_line ();

            assign mic_line.clk_rise = state_ff.rise;
            assign mic_line.clk_fall = state_ff.fall;
            assign mic_line.data = state_ff.line_data[g];
            assign mic_line.edge_swap = line_edge[g];
            assign mic_line.enable = state_ff.line_enable[g];

            apr_mic_capture u_capture (
                .sys_clk_in(sys_clk_in),
                .reset_in(reset_in),
                .line(mic_line.capture)
            );

            assign mic_channel_bit_out[2*g] = mic_line.first_bit;
            assign mic_channel_bit_out[2*g+1] = mic_line.second_bit;
            assign mic_channel_strobe_out[2*g] = mic_line.first_strobe;
            assign mic_channel_strobe_out[2*g+1] = mic_line.second_strobe;
        end
    endgenerate

    // ==========
    // Outputs
    assign reg_rdata_out = state_ff.rdata;
    assign data_out_pin_out = state_ff.dout_drive;
    assign data_out_pin_oe_n_out = state_ff.dout_oe_n;
    assign primary_data_input_out = state_ff.prim_data;
    assign second_port_enable_out = state_ff.sp_enable;
    assign second_port_frame_out = state_ff.sp_frame;
    assign second_port_bitclock_out = state_ff.sp_bclk;
    assign second_port_input_one_out = state_ff.sp_in1;
    assign second_port_input_two_out = state_ff.sp_in2;
    assign channel_one_digital_out = state_ff.ch1_digital;
    assign channel_two_digital_out = state_ff.ch2_digital;
    assign converter_powered_down_out = state_ff.powered_down;
    assign aux_function_on_pin_one_out = state_ff.aux_on_pin1;
endmodule : apr_pin_routing

`default_nettype wire

// [sim/apr_properties.sv]
// Port assertions for the audio pin routing top.
// Assumes one system clock and an active high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module apr_properties (
    // Clock, reset and register port
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    // Pins and status
    input wire logic primary_data_out_in,
    input wire logic data_out_pin_out,
    input wire logic data_out_pin_oe_n_out,
    input wire logic converter_powerdown_control_in,
    input wire logic converter_powered_down_out,
    input wire logic [3:0] mic_channel_strobe_out
);
    // ==========
    // Properties
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    chk_oe_idle: assert property (
        data_out_pin_oe_n_out |-> !data_out_pin_out) else $error("oe idle");
    chk_dout_follow: assert property (
        !data_out_pin_oe_n_out [*2] |->
        data_out_pin_out == $past(primary_data_out_in)) else $error("dout");
    chk_rsv_clk: assert property (
        reg_read_in && reg_addr_in == 8'h11 |=> !reg_rdata_out[0])
        else $error("rsv clk");
    chk_rsv_ovr: assert property (
        reg_read_in && reg_addr_in == 8'h14 |=> reg_rdata_out[3:1] == 3'h0)
        else $error("rsv ovr");
    chk_unmapped_read: assert property (
        reg_read_in && reg_addr_in > 8'h14 |=> reg_rdata_out == 8'h00)
        else $error("unmapped");
    chk_pd_request: assert property (
        converter_powerdown_control_in |=> converter_powered_down_out)
        else $error("pd");
    chk_strobe_pulse: assert property (
        |mic_channel_strobe_out |=> mic_channel_strobe_out == 4'h0)
        else $error("strobe");
    chk_strobe_pair: assert property (
        !(&mic_channel_strobe_out[1:0]) && !(&mic_channel_strobe_out[3:2]))
        else $error("pair");
    cov_line_one: cover property (mic_channel_strobe_out[0]);
    cov_line_two: cover property (mic_channel_strobe_out[3]);
    cov_pin_driven: cover property (!data_out_pin_oe_n_out);
endmodule : apr_properties

bind apr_pin_routing apr_properties i_apr_properties (.*);

`default_nettype wire

// [sim/apr_mic_model.sv]
// Two microphones sharing one data line and one bit clock.
// Assumes the bench calls send_pair once per clock period.
`timescale 1ns/1ps
`default_nettype none

module apr_mic_model (
    // Microphone pins
    output logic mic_clk_out,
    output logic mic_data_out
);
    initial {mic_clk_out, mic_data_out} = 2'b00;
    // ==========
    // One 125 ns period; the clock stands low between calls and the
    // released line shows the inverse of its last bit.
    task automatic send_pair(input logic first_bit, input logic second_bit);
        mic_data_out = second_bit;
        #31.25 mic_clk_out = 1'b1;
        #31.25 mic_data_out = first_bit;
        #31.25 mic_clk_out = 1'b0;
        #31.25 mic_data_out = ~first_bit;
    endtask : send_pair
endmodule : apr_mic_model

`default_nettype wire

// [sim/tb_apr_pin_routing.sv]
// Self-checking bench for the audio pin routing top.
// Assumes apr_mic_model stands in for the microphones.
`include "apr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_apr_pin_routing;
    logic clk, rst, wr, rd, pdc, ext, pdo, pf, pb, use_mic, mclk, mdat;
    logic dpo, doe_n, dpin, pdi, spe, spf, spb, si1, si2, cd1, cd2, pdn, aux;
    logic [7:0] addr, wd, rdat;
    logic [3:0] pin, mb, ms;
    logic [31:0] v;
    int error_cnt = 0;
    int cmp_count = 0;
    int i, c;
    int msk[5] = '{`APR_MASK_DOUT_CFG, `APR_MASK_CLK_ROUTE,
        `APR_MASK_DATA_ROUTE, `APR_MASK_MIC_CFG, `APR_MASK_OVERRIDES};
    int mir[5] = '{`APR_RST_DOUT_CFG, `APR_RST_CLK_ROUTE,
        `APR_RST_DATA_ROUTE, `APR_RST_MIC_CFG, `APR_RST_OVERRIDES};
    // The pin level is ours only while the block releases it.
    assign dpin = doe_n ? ext : dpo;

    apr_pin_routing i_apr_pin_routing (
        .sys_clk_in(clk), .reset_in(rst), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_write_in(wr), .reg_read_in(rd),
        .reg_rdata_out(rdat), .general_io_pin_one_in(pin[1]),
        .input_pin_2a_in(use_mic ? mdat : pin[2]), .input_pin_1a_in(pin[3]),
        .serial_data_in(use_mic ? mdat : pin[0]), .data_out_pin_in(dpin),
        .data_out_pin_out(dpo), .data_out_pin_oe_n_out(doe_n),
        .primary_frame_in(pf), .primary_bitclock_in(pb),
        .primary_data_out_in(pdo), .primary_data_input_out(pdi),
        .second_port_enable_out(spe), .second_port_frame_out(spf),
        .second_port_bitclock_out(spb), .second_port_input_one_out(si1),
        .second_port_input_two_out(si2), .mic_bit_clock_in(mclk),
        .channel_one_digital_out(cd1), .channel_two_digital_out(cd2),
        .mic_channel_bit_out(mb), .mic_channel_strobe_out(ms),
        .converter_powerdown_control_in(pdc),
        .converter_powered_down_out(pdn), .aux_function_on_pin_one_out(aux));
    apr_mic_model i_apr_mic_model (.mic_clk_out(mclk), .mic_data_out(mdat));

    // ==========
    // Tasks
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr8(logic [7:0] a, logic [7:0] d);
        addr = a; wd = d; wr = 1'b1;
        if (a >= 8'h10 && a <= 8'h14) mir[a - 8'h10] = d & msk[a - 8'h10];
        @(posedge clk) #1 wr = 1'b0;
        @(posedge clk) #1;
    endtask : wr8
    task automatic rd8(logic [7:0] a);
        addr = a; rd = 1'b1;
        @(posedge clk) #1 rd = 1'b0;
        @(posedge clk) #1;
        chk("reg", rdat, a < 8'h15 ? mir[a - 8'h10] : 0);
    endtask : rd8
    function automatic logic pick(int c, logic p5, logic d4);
        return c inside {[1:3]} ? pin[c] : c == 4 ? d4 : c == 5 ? p5 : 1'b0;
    endfunction : pick
    task automatic finish_test();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    // ==========
    // Clock, watchdog and tests
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #100us error_cnt++;
        finish_test();
    end
    initial begin
        rst = 1'b1;
        {wr, rd, addr, wd, pin, ext, pdo, pf, pb, pdc, use_mic} = '0;
        void'($urandom(32'hd4cc));
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        for (i = 16; i < 22; i++) rd8(i);
        for (i = 16; i < 22; i++) wr8(i, 8'hff);
        for (i = 16; i < 22; i++) rd8(i);
        wr8(8'h10, 8'h10);
        for (i = 0; i < 24; i++) begin
            c = i % 8;
            v = $urandom;
            {pdc, pb, pf, ext, pin} = v[7:0];
            wr8(8'h11, {v[8], c[2:0], c[2:0], 1'b0});
            wr8(8'h12, {c[2:0], c[2:0], 2'b00});
            wr8(8'h14, {2'b00, v[10:9], 3'h0, v[11]});
            repeat (5) @(posedge clk) #1;
            chk("frame", spf, pick(c, pf, 0));
            chk("bclk", spb, pick(c, pb, 0));
            chk("in1", si1, pick(c, pin[0], ext));
            chk("in2", si2, pick(c, pin[0], ext));
            chk("enable", spe, c inside {[1:3], 5});
            chk("prim", pdi, v[8] & pin[0]);
            chk("pd", pdn, pdc | (v[10:9] != 0 && pin[v[10:9]]));
            chk("aux", aux, v[11]);
            chk("oe", doe_n, 1);
        end
        pdo = 1'b1;
        wr8(8'h14, 8'h40);
        repeat (3) @(posedge clk) #1;
        chk("oe", doe_n, 0);
        chk("dout", dpo, 1);
        use_mic = 1'b1;
        wr8(8'h14, 8'h80);
        for (i = 0; i < 8; i++) begin
            v = $urandom;
            wr8(8'h13, {v[3:2], i[0], i[1], 4'hb});
            i_apr_mic_model.send_pair(v[4], v[5]);
            repeat (8) @(posedge clk);
            #1 chk("ch1", cd1, v[3]);
            chk("ch2", cd2, v[2]);
            chk("l1", mb[1:0], i[0] ? {v[4], v[5]} : v[5:4]);
            chk("l2", mb[3:2], i[1] ? {v[4], v[5]} : v[5:4]);
        end
        finish_test();
    end
endmodule : tb_apr_pin_routing

`default_nettype wire
